/* verilog/sensor_i2c_cfg.svh */
`ifndef SENSOR_I2C_CFG_SVH
`define SENSOR_I2C_CFG_SVH
// ==========================================================
// Bus address
// Upper six bits of the slave address; LSB comes from the strap
`define ADDR_HI 6'h35
// ==========================================================
// Register map
`define REG_CTRL12 8'h12
`define REG_CTRL13 8'h13
// Field positions
`define BIT_AUTO_INC 2
`define BIT_THREE_WIRE 3
`define BIT_I2C_OFF 2
// Reset values
`define CTRL12_RST 8'h04
// ==========================================================
// Bit counting
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define CNT_BYTE 4'h8
`define LCNT_ZERO 3'h0
`define LCNT_ONE 3'h1
`define LCNT_LAST 3'h7
`define IDX_STEP 8'h01
`endif

/* verilog/sensor_i2c_pkg.sv */
package sensor_i2c_pkg;
	// ==========================================================
	// Two-wire slave states
	typedef enum logic [3:0] {
		IDLE = 4'b0000,
		GET_ADDR = 4'b0001,
		ACK_ADDR = 4'b0010,
		GET_SUB = 4'b0011,
		ACK_SUB = 4'b0100,
		GET_DATA = 4'b0101,
		ACK_DATA = 4'b0110,
		SEND_DATA = 4'b0111,
		WAIT_ACK = 4'b1000
	} i2c_state_e;

	typedef logic [255:0][7:0] reg_file_t;

	// ==========================================================
	// State on mclk
	typedef struct packed {
		reg_file_t regs;
		i2c_state_e st;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic [7:0] idx;
		logic rw;
		logic masterAck;
		logic slaveAck;
		logic busy;
		logic [1:0] sclSy;
		logic [1:0] sdaSy;
		logic [1:0] csSy;
		logic [1:0] strapSy;
		logic sclPrev;
		logic sdaPrev;
		logic [2:0] evSy;
		logic [7:0] spiIdx;
		logic spiRw;
		logic [7:0] rdWord;
	} core_s;

	// ==========================================================
	// State on the serial port clock
	typedef struct packed {
		logic [2:0] cnt;
		logic cmdDone;
		logic rw;
		logic [7:0] rx;
		logic [7:0] tx;
		logic evTog;
		logic evCmd;
		logic [7:0] evWord;
	} link_s;
endpackage : sensor_i2c_pkg

/* verilog/sensor_i2c_register_slave.sv */
// What this block does
// - Chip select low: serial-peripheral; high: two-wire
// - Serial-peripheral accepts clock modes 0 and 3
// - Software picks 3-wire or 4-wire serial-peripheral
// - Disable bit at 13h shuts two-wire slave
// - Two-wire slave runs up to 400 kHz
// - Start: SDA falls, SCL high; bus busy
// - Stop: SDA rises, SCL high; return idle
// - First byte: 7-bit address plus direction
// - Join transfer only when address matches
// - Address 110101 plus strap pin level
// - Shared pin: strap, or 4-wire data output
// - Transmitter releases SDA; receiver holds low
// - Acknowledge address, sub-address, every write byte
// - Sub-address byte latched as register index
// - Index stepping chosen by bit at 12h
// - Send bytes while master acknowledges; stop ends
// - Eight-bit bytes, MSB first, any count
// - Receiver may stretch SCL; transmitter waits; this slave never holds SCL low
// - No match: leave SDA high at acknowledge
// - Idle bus: nobody drives either line
// - Auto-increment 1 steps index, 0 holds
// - Three-wire select bit at 12h enables 3-wire
`timescale 1ns/1ps
`default_nettype none
`include "sensor_i2c_cfg.svh"

module sensor_i2c_register_slave
	import sensor_i2c_pkg::*;
(
	// System clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Interface select, low for serial-peripheral
	input wire logic spiSelectN,
	// Shared SCL / serial port clock
	input wire logic serialPortClockPin,
	// Shared SDA / serial input pin
	input wire logic serialInPinIn,
	output logic serialInPinOut,
	output logic serialInPinOe,
	// Shared serial output / address strap pin
	input wire logic outputOrStrapPinIn,
	output logic outputOrStrapPinOut,
	output logic outputOrStrapPinOe,
	// Status
	output logic busBusy
);

	// ==========================================================
	// Helpers
	// Next register index, stepping only when enabled
	function automatic logic [7:0] nextIndex(input logic [7:0] idx, input logic inc);
		nextIndex = inc ? idx + `IDX_STEP : idx;
	endfunction : nextIndex

	core_s cr_reg;
	core_s cr_next;
	link_s ln_reg;
	link_s ln_next;

	logic scl;
	logic sda;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	logic i2cOn;
	logic autoInc;
	logic threeWire;
	logic addrMatch;
	logic spiEvent;
	logic spiDrive;
	logic spiBit;

	// ==========================================================
	// Decoded line events, all from synchronised samples
	assign scl = cr_reg.sclSy[1];
	assign sda = cr_reg.sdaSy[1];
	assign sclRise = scl && !cr_reg.sclPrev;
	assign sclFall = !scl && cr_reg.sclPrev;
	assign startCond = scl && cr_reg.sdaPrev && !sda;
	assign stopCond = scl && !cr_reg.sdaPrev && sda;
	// Chip select high and not disabled by software
	assign i2cOn = cr_reg.csSy[1] && !cr_reg.regs[`REG_CTRL13][`BIT_I2C_OFF];
	assign autoInc = cr_reg.regs[`REG_CTRL12][`BIT_AUTO_INC];
	assign threeWire = cr_reg.regs[`REG_CTRL12][`BIT_THREE_WIRE];
	assign addrMatch = cr_reg.shift[7:1] == {`ADDR_HI, cr_reg.strapSy[1]};
	assign spiEvent = cr_reg.evSy[1] ^ cr_reg.evSy[2];

	// ==========================================================
	// Core next state on mclk
	// Oversampling at 25 MHz leaves over 60 samples per 400 kHz bit
	always_comb begin
		cr_next = cr_reg;
		cr_next.sclSy = {cr_reg.sclSy[0], serialPortClockPin};
		cr_next.sdaSy = {cr_reg.sdaSy[0], serialInPinIn};
		cr_next.csSy = {cr_reg.csSy[0], spiSelectN};
		cr_next.strapSy = {cr_reg.strapSy[0], outputOrStrapPinIn};
		cr_next.sclPrev = cr_reg.sclSy[1];
		cr_next.sdaPrev = cr_reg.sdaSy[1];
		cr_next.evSy = {cr_reg.evSy[1:0], ln_reg.evTog};

		if (!i2cOn) begin
			cr_next.st = IDLE;
			cr_next.slaveAck = 1'b0;
			cr_next.busy = 1'b0;
		end else if (startCond) begin
			// Repeated start lands here too, index is kept
			cr_next.st = GET_ADDR;
			cr_next.cnt = `CNT_ZERO;
			cr_next.slaveAck = 1'b0;
			cr_next.busy = 1'b1;
		end else if (stopCond) begin
			cr_next.st = IDLE;
			cr_next.slaveAck = 1'b0;
			cr_next.busy = 1'b0;
		end else begin
			// SCL is never held low here: registers answer at once
			case (cr_reg.st)
				GET_ADDR, GET_SUB, GET_DATA: begin
					if (sclRise) begin
						cr_next.shift = {cr_reg.shift[6:0], sda};
						cr_next.cnt = cr_reg.cnt + `CNT_ONE;
					end else if (sclFall && cr_reg.cnt == `CNT_BYTE) begin
						cr_next.cnt = `CNT_ZERO;
						cr_next.slaveAck = 1'b1;
						if (cr_reg.st == GET_ADDR) begin
							if (addrMatch) begin
								cr_next.rw = cr_reg.shift[0];
								cr_next.st = ACK_ADDR;
							end else begin
								// Not ours: SDA stays released
								cr_next.slaveAck = 1'b0;
								cr_next.st = IDLE;
							end
						end else if (cr_reg.st == GET_SUB) begin
							cr_next.idx = cr_reg.shift;
							cr_next.st = ACK_SUB;
						end else begin
							cr_next.regs[cr_reg.idx] = cr_reg.shift;
							cr_next.st = ACK_DATA;
						end
					end
				end
				ACK_ADDR: begin
					if (sclFall) begin
						cr_next.slaveAck = 1'b0;
						if (cr_reg.rw) begin
							cr_next.tx = cr_reg.regs[cr_reg.idx];
							cr_next.slaveAck = !cr_reg.regs[cr_reg.idx][7];
							cr_next.st = SEND_DATA;
						end else begin
							cr_next.st = GET_SUB;
						end
					end
				end
				ACK_SUB: begin
					if (sclFall) begin
						cr_next.slaveAck = 1'b0;
						cr_next.st = GET_DATA;
					end
				end
				ACK_DATA: begin
					if (sclFall) begin
						cr_next.slaveAck = 1'b0;
						cr_next.idx = nextIndex(cr_reg.idx, autoInc);
						cr_next.st = GET_DATA;
					end
				end
				SEND_DATA: begin
					if (sclRise) begin
						cr_next.cnt = cr_reg.cnt + `CNT_ONE;
					end else if (sclFall) begin
						if (cr_reg.cnt == `CNT_BYTE) begin
							// Release for the master's acknowledge
							cr_next.slaveAck = 1'b0;
							cr_next.cnt = `CNT_ZERO;
							cr_next.st = WAIT_ACK;
						end else begin
							cr_next.tx = {cr_reg.tx[6:0], 1'b0};
							cr_next.slaveAck = !cr_reg.tx[6];
						end
					end
				end
				WAIT_ACK: begin
					if (sclRise) begin
						cr_next.masterAck = !sda;
					end else if (sclFall) begin
						if (cr_reg.masterAck) begin
							cr_next.idx = nextIndex(cr_reg.idx, autoInc);
							cr_next.tx = cr_reg.regs[nextIndex(cr_reg.idx, autoInc)];
							cr_next.slaveAck = !cr_reg.regs[nextIndex(cr_reg.idx, autoInc)][7];
							cr_next.st = SEND_DATA;
						end else begin
							// No acknowledge: wait for the stop
							cr_next.st = IDLE;
						end
					end
				end
				default: begin
					cr_next.slaveAck = 1'b0;
				end
			endcase
		end

		// Serial-peripheral byte events from the port clock domain
		if (!cr_reg.csSy[1] && spiEvent) begin
			if (ln_reg.evCmd) begin
				cr_next.spiRw = ln_reg.evWord[7];
				cr_next.spiIdx = {1'b0, ln_reg.evWord[6:0]};
				cr_next.rdWord = cr_reg.regs[{1'b0, ln_reg.evWord[6:0]}];
			end else begin
				if (!cr_reg.spiRw) begin
					cr_next.regs[cr_reg.spiIdx] = ln_reg.evWord;
				end
				cr_next.spiIdx = nextIndex(cr_reg.spiIdx, autoInc);
				cr_next.rdWord = cr_reg.regs[nextIndex(cr_reg.spiIdx, autoInc)];
			end
		end
	end

	// Core register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cr_reg <= '0;
			cr_reg.regs[`REG_CTRL12] <= `CTRL12_RST;
		end else begin
			cr_reg <= cr_next;
		end
	end

	// ==========================================================
	// Serial-peripheral link logic on the port clock
	// Both modes sample on the rising edge, so one path serves both
	always_comb begin
		ln_next = ln_reg;
		ln_next.rx = {ln_reg.rx[6:0], serialInPinIn};
		ln_next.cnt = ln_reg.cnt + `LCNT_ONE;
		// rdWord is held by mclk long before this edge reads it
		if (ln_reg.cnt == `LCNT_ZERO && ln_reg.cmdDone && ln_reg.rw) begin
			ln_next.tx = {cr_reg.rdWord[6:0], 1'b0};
		end else begin
			ln_next.tx = {ln_reg.tx[6:0], 1'b0};
		end
		if (ln_reg.cnt == `LCNT_LAST) begin
			// Toggle marks a whole byte, word stays put for 8 edges
			ln_next.evTog = !ln_reg.evTog;
			ln_next.evWord = {ln_reg.rx[6:0], serialInPinIn};
			ln_next.evCmd = !ln_reg.cmdDone;
			ln_next.cmdDone = 1'b1;
			if (!ln_reg.cmdDone) begin
				ln_next.rw = ln_reg.rx[6];
			end
		end
	end

	// Chip select high clears the frame, even with the clock stopped
	always_ff @(posedge serialPortClockPin or posedge spiSelectN) begin
		if (spiSelectN) begin
			ln_reg <= '0;
		end else begin
			ln_reg <= ln_next;
		end
	end

	// ==========================================================
	// Pin drive
	assign spiDrive = !spiSelectN && ln_reg.cmdDone && ln_reg.rw;
	// First data bit comes straight from the held word
	assign spiBit = (ln_reg.cnt == `LCNT_ZERO) ? cr_reg.rdWord[7] : ln_reg.tx[7];
	// SDA is pulled low by the two-wire slave, and driven high or low by 3-wire serial-peripheral reads
	assign serialInPinOe = cr_reg.slaveAck || (spiDrive && threeWire);
	assign serialInPinOut = spiDrive && threeWire && spiBit;
	// Strap pin turns into data output only in 4-wire reads
	assign outputOrStrapPinOe = spiDrive && !threeWire;
	assign outputOrStrapPinOut = spiBit;
	assign busBusy = cr_reg.busy;

	// ==========================================================
	// Checks
	start_busy_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(i2cOn && startCond) |=> (cr_reg.st == GET_ADDR) && busBusy)
		else $error("start not taken");

	stop_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(i2cOn && stopCond && !startCond) |=> (cr_reg.st == IDLE) && !busBusy
			&& !serialInPinOe)
		else $error("stop did not return idle");

	cs_low_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(!cr_reg.csSy[1]) |=> !cr_reg.slaveAck && (cr_reg.st == IDLE))
		else $error("two-wire active under chip select");

	disable_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cr_reg.regs[`REG_CTRL13][`BIT_I2C_OFF] |=> (cr_reg.st == IDLE)
			&& !cr_reg.slaveAck)
		else $error("two-wire active while disabled");

	addr_nak_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(i2cOn && !startCond && !stopCond && sclFall && cr_reg.st == GET_ADDR
			&& cr_reg.cnt == `CNT_BYTE && !addrMatch)
		|=> !cr_reg.slaveAck [*2])
		else $error("acknowledged foreign address");

	addr_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(i2cOn && !startCond && !stopCond && sclFall && cr_reg.st == GET_ADDR
			&& cr_reg.cnt == `CNT_BYTE && addrMatch)
		|=> cr_reg.slaveAck && (cr_reg.st == ACK_ADDR)
			&& (cr_reg.rw == $past(cr_reg.shift[0])))
		else $error("own address not acknowledged");

	sub_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(i2cOn && !startCond && !stopCond && sclFall && cr_reg.st == GET_SUB
			&& cr_reg.cnt == `CNT_BYTE)
		|=> (cr_reg.idx == $past(cr_reg.shift)) && (cr_reg.st == ACK_SUB))
		else $error("sub-address not latched");

	ack_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(cr_reg.st == ACK_DATA && i2cOn && !sclFall && !startCond && !stopCond)
		|=> cr_reg.slaveAck)
		else $error("write byte acknowledge dropped");

	step_index_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(i2cOn && !startCond && !stopCond && sclFall && cr_reg.st == ACK_DATA)
		|=> cr_reg.idx == ($past(autoInc) ? $past(cr_reg.idx) + `IDX_STEP
			: $past(cr_reg.idx)))
		else $error("index step wrong");

	release_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(cr_reg.st == WAIT_ACK) |-> !cr_reg.slaveAck)
		else $error("SDA driven during master acknowledge");

	three_wire_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(outputOrStrapPinOe |-> !threeWire) and (outputOrStrapPinOe |-> !serialInPinOe))
		else $error("serial output on wrong pin");

	// Read word must come from the indexed register before its MSB leaves
	read_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(i2cOn && !startCond && !stopCond && sclFall && cr_reg.st == ACK_ADDR && cr_reg.rw)
		|=> (cr_reg.tx == $past(cr_reg.regs[cr_reg.idx])) && (cr_reg.st == SEND_DATA))
		else $error("read byte not loaded");

	master_nak_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(i2cOn && !startCond && !stopCond && sclFall && cr_reg.st == WAIT_ACK
			&& !cr_reg.masterAck)
		|=> (cr_reg.st == IDLE) && !cr_reg.slaveAck)
		else $error("kept sending after no acknowledge");

	idle_released_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(cr_reg.st == IDLE) |-> !cr_reg.slaveAck)
		else $error("data line held low on idle bus");

	// Strap pin is an input whenever the two-wire side owns the pins
	strap_input_a: assert property (@(posedge mclk) disable iff (!rst_n)
		spiSelectN |-> !outputOrStrapPinOe && !(serialInPinOe && serialInPinOut))
		else $error("shared pin driven in two-wire mode");

	// Each falling edge inside a byte moves the next bit out
	data_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(i2cOn && !startCond && !stopCond && sclFall && cr_reg.st == SEND_DATA
			&& cr_reg.cnt != `CNT_BYTE)
		|=> (cr_reg.tx == {$past(cr_reg.tx[6:0]), 1'b0})
			&& (cr_reg.slaveAck == !$past(cr_reg.tx[6])))
		else $error("read bit not shifted");

	spi_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(!cr_reg.csSy[1] && spiEvent && !ln_reg.evCmd)
		|=> cr_reg.spiIdx == ($past(autoInc) ? $past(cr_reg.spiIdx) + `IDX_STEP
			: $past(cr_reg.spiIdx)))
		else $error("serial-peripheral index step wrong");

endmodule : sensor_i2c_register_slave
`default_nettype wire

/* bench/bus_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
	// Pacing clock
	input wire logic mclk,
	// Host-driven lines
	output logic csN,
	output logic scl,
	output logic sdaM,
	// Lines read back
	input wire logic sda,
	input wire logic serial_out_pin
);
	// ==========================================
	// Two-wire master
	// Clocks per phase; bit period near 397 kHz
	localparam int T = 21;
	// Idle: chip select high, both lines released
	initial begin
		csN = 1'b1;
		scl = 1'b1;
		sdaM = 1'b1;
	end
	// Phase wait, always 1 ns after the edge
	task automatic tick();
		repeat (T) @(posedge mclk);
		#1;
	endtask : tick
	// SDA falls while SCL high; also a repeated start
	task automatic start();
		tick();
		sdaM = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sdaM = 1'b0;
		tick();
		scl = 1'b0;
	endtask : start
	// SDA rises while SCL high
	task automatic stop();
		tick();
		sdaM = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sdaM = 1'b1;
		tick();
	endtask : stop
	// Eight bits MSB first, then the acknowledge slot; no SCL wait, slave never stretches
	task automatic xfer(input logic [7:0] b, input logic ackIn, output logic [7:0] rx,
		output logic ack);
		for (int i = 0; i < 9; i++) begin
			tick();
			sdaM = (i < 8) ? b[7 - i] : ackIn;
			tick();
			scl = 1'b1;
			tick();
			if (i < 8) rx = {rx[6:0], sda};
			else ack = sda;
			scl = 1'b0;
		end
	endtask : xfer
	// ==========================================
	// Serial-peripheral master, 15 ns clock
	// Clock idles at the mode level; first data bit gets a long low phase
	task automatic spi(input logic m3, input logic w3, input logic [7:0] cmd,
		input logic [7:0] dat, output logic [7:0] rx);
		logic [15:0] s;
		s = {cmd, dat};
		scl = m3;
		#20 csN = 1'b0;
		#20;
		for (int i = 0; i < 16; i++) begin
			scl = 1'b0;
			sdaM = s[15 - i];
			#(i == 8 ? 250 : 7.5);
			rx = {rx[6:0], w3 ? sda : serial_out_pin};
			scl = 1'b1;
			#7.5;
		end
		#200 scl = m3;
		#20 csN = 1'b1;
		sdaM = 1'b1;
		#100;
	endtask : spi
endmodule : bus_master_model
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ==========================================
	// Signals
	logic mclk, rst_n, strap, busy, dOut, dOe, sOut, sOe, csN, scl, sdaM, ack;
	wire logic sda;
	wire logic serial_out_pin;
	logic [7:0] exp [256];
	logic [7:0] rx, d0, d1;
	int fails, checksDone, cyc, seed;
	// Pulled-up data wire; strap level unless the device drives the pin
	assign sda = (dOe ? dOut : 1'b1) & sdaM;
	assign serial_out_pin = sOe ? sOut : strap;
	sensor_i2c_register_slave DUT (.mclk(mclk), .rst_n(rst_n), .spiSelectN(csN),
		.serialPortClockPin(scl), .serialInPinIn(sda), .serialInPinOut(dOut),
		.serialInPinOe(dOe), .outputOrStrapPinIn(serial_out_pin), .outputOrStrapPinOut(sOut),
		.outputOrStrapPinOe(sOe), .busBusy(busy));
	bus_master_model M (.mclk(mclk), .csN(csN), .scl(scl), .sdaM(sdaM), .sda(sda),
		.serial_out_pin(serial_out_pin));
	// Clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Hang guard, generous over the expected run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			stop_test();
		end
	end
	// ==========================================
	// Tasks
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] want);
		checksDone++;
		if (seen !== want) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, want, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	// Address, sub-address and two data bytes, each acknowledged
	task automatic wr(input logic [7:0] sub, input logic [7:0] v0, input logic [7:0] v1);
		logic [7:0] b [4];
		b = '{{6'b110101, strap, 1'b0}, sub, v0, v1};
		M.start();
		check("busy", busy, 8'h01);
		for (int i = 0; i < 4; i++) begin
			M.xfer(b[i], 1'b1, rx, ack);
			check("ack", ack, 8'h00);
		end
		exp[sub] = v0;
		exp[sub + exp[8'h12][2]] = v1;
		M.stop();
		check("busy", busy, 8'h00);
	endtask : wr
	// Sub-address write, repeated start, n bytes read; the last not acknowledged
	task automatic rd(input logic [7:0] sub, input int n);
		logic [7:0] b [3];
		b = '{{6'b110101, strap, 1'b0}, sub, {6'b110101, strap, 1'b1}};
		M.start();
		for (int i = 0; i < 3; i++) begin
			if (i == 2) M.start();
			M.xfer(b[i], 1'b1, rx, ack);
			check("ack", ack, 8'h00);
		end
		for (int i = 0; i < n; i++) begin
			M.xfer(8'hff, i == n - 1, rx, ack);
			check("rdata", rx, exp[sub + i * exp[8'h12][2]]);
		end
		M.stop();
		check("busy", busy, 8'h00);
	endtask : rd
	// Serial-peripheral frame; a read compares the returned byte
	task automatic spi(input logic m3, input logic isRd, input logic [6:0] r,
		input logic [7:0] v);
		M.spi(m3, exp[8'h12][3], {isRd, r}, isRd ? 8'hff : v, rx);
		if (isRd) check("spi", rx, exp[r]);
		else exp[r] = v;
	endtask : spi
	// ==========================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		strap = 1'b0;
		seed = 97227;
		foreach (exp[i]) exp[i] = 8'h00;
		exp[8'h12] = 8'h04;
		repeat (16) @(posedge mclk);
		#1 rst_n = 1'b1;
		check("idle", {dOe, sOe, busy}, 8'h00);
		repeat (4) @(posedge mclk);
		strap = 1'($random(seed));
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		wr(8'h40, d0, d1);
		rd(8'h40, 3);
		// Other strap level: must be ignored
		M.start();
		M.xfer({6'b110101, ~strap, 1'b0}, 1'b1, rx, ack);
		check("nack", ack, 8'h01);
		M.stop();
		spi(1'b1, 1'b0, 7'h13, 8'h04);
		check("busy", busy, 8'h00);
		M.start();
		M.xfer({6'b110101, strap, 1'b0}, 1'b1, rx, ack);
		check("off", {busy, ack}, 8'h01);
		M.stop();
		spi(1'b0, 1'b0, 7'h13, 8'h00);
		spi(1'b0, 1'b1, 7'h41, 8'h00);
		spi(1'b1, 1'b1, 7'h40, 8'h00);
		// Three-wire mode, fixed index
		spi(1'b1, 1'b0, 7'h12, 8'h08);
		spi(1'b1, 1'b1, 7'h40, 8'h00);
		wr(8'h50, 8'($random(seed)), 8'($random(seed)));
		rd(8'h50, 2);
		stop_test();
	end
endmodule : tb
`default_nettype wire
